// file: logic/bis_map.vh
// constants of the bootstrap start-up sequencer: register indexes,
// field layouts, reset values and timing counts
// assumes a 200 MHz system clock and an APB register port
`ifndef BIS_MAP_VH
`define BIS_MAP_VH

// system clock rate and period
`define BIS_CLK_MHZ        200
`define BIS_CLK_NS         5

// register indexes; byte address is four times the index
`define BIS_ASSOC12_IDX    10'h1A6
`define BIS_ASSOC34_IDX    10'h1A7
`define BIS_ASSOC5_IDX     10'h1A8
`define BIS_STATUS_IDX     10'h1A9

// association fields: six low-side bits per high-side channel
`define BIS_LS_NUM         6
`define BIS_ODD_LSB        0
`define BIS_EVEN_LSB       8
`define BIS_ASSOC_MASK     16'h3F3F
`define BIS_ASSOC12_RST    16'h3F3F
`define BIS_ASSOC34_RST    16'h3F3F
`define BIS_ASSOC5_RST     16'h003F

// status fields
`define BIS_ST_INIT_LSB    0
`define BIS_ST_DONE_LSB    5
`define BIS_ST_WIN_BIT     10
`define BIS_ST_RUN_BIT     11
`define BIS_ST_RDY_BIT     12

// low source threshold window after supply rise, in ms
`define BIS_WIN_MS         36
`define BIS_WIN_CYC        (`BIS_WIN_MS * 1000 * `BIS_CLK_MHZ)
`define BIS_WIN_W          23

// charge pump start-up time in us, and its clock rate in MHz
`define BIS_CPINIT_US      10
`define BIS_CPINIT_CYC     (`BIS_CPINIT_US * `BIS_CLK_MHZ)
`define BIS_CPINIT_W       11
`define BIS_CP_MHZ         28
`define BIS_CP_DIV         ((`BIS_CLK_MHZ + `BIS_CP_MHZ / 2) / `BIS_CP_MHZ)
`define BIS_CP_DIV_W       3

`endif

// file: logic/bis_channel.v
// one high-side channel's start-up sequencer: idle, initializing, done
// assumes start and exit requests arrive synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module bis_channel
(
   input  wire clk,
   input  wire resetn,
   input  wire start,
   input  wire exitReq,
   output wire initializing,
   output wire done
);

   // state codes
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_INIT = 2'b01;
   localparam [1:0] ST_DONE = 2'b10;

   reg  [1:0] state;       // current state
   reg  [1:0] next_state;  // next state

   // next-state logic
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            // start charging once supply is qualified
            if (start)
               next_state = ST_INIT;
         end
         ST_INIT:
         begin
            // any exit condition ends this channel's phase
            if (exitReq)
               next_state = ST_DONE;
         end
         ST_DONE:
         begin
            // held until the next reset
            next_state = ST_DONE;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // state register
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // decoded state outputs
   assign initializing = (state == ST_INIT);
   assign done         = (state == ST_DONE);

endmodule

`default_nettype wire

// file: logic/bis_sequencer.v
// bootstrap start-up sequencer for five high-side pre-drivers with APB registers
// assumes analog comparator levels arrive asynchronously on pins, and that
// low/high-side switch requests come from logic on mclk
//
// Contract
// - supply qualified: bias low sides, start charging
// - during init: limit, force comparator, bias
// - bootstrap near supply, source low: exit
// - clamp active, source low: exit
// - associated low-side switched on: exit
// - association cleared in configuration: exit
// - own high-side switched on: exit
// - association from three configuration registers
// - pump runs with 5V, boost, no POR
// - high sides off under boost undervoltage
// - pump source charges while below pump
// - pump clocked near 28 MHz
// - pump output ready 10 us after enable
// - bootstrap inhibit while no low-side on
// - gate low on reset or driver disable
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bis_map.vh"

module bis_sequencer
#(
   parameter integer HS_NUM  = 5,               // high-side channels
   parameter integer LS_NUM  = `BIS_LS_NUM,     // low-side pre-drivers
   parameter integer WIN_CYC = `BIS_WIN_CYC     // low threshold window, cycles
)
(
   input  wire              mclk,
   input  wire              resetn,
   // apb slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output wire              pslverr,
   output reg  [31:0]       prdata,
   // asynchronous pins and comparators
   input  wire              device_reset_n,
   input  wire              driverEnable,
   input  wire              poweron_reset_n,
   input  wire              logic_supply_5v,
   input  wire              boost_supply,
   input  wire              supply_uv_rise_threshold,
   input  wire [HS_NUM-1:0] bootNearSupply,
   input  wire [HS_NUM-1:0] bootstrap_clamp,
   input  wire [HS_NUM-1:0] srcBelowLow,
   input  wire [HS_NUM-1:0] srcBelowHigh,
   input  wire [HS_NUM-1:0] bootBelowPump,
   // switch requests from microcores or serial host
   input  wire [LS_NUM-1:0] lsOnReq,
   input  wire [HS_NUM-1:0] hsOnReq,
   input  wire [HS_NUM-1:0] injectionEnd,
   // outputs to the analog side
   output reg               lsBiasEn,
   output reg  [HS_NUM-1:0] hsBiasEn,
   output reg  [HS_NUM-1:0] diodeLimit,
   output reg  [HS_NUM-1:0] source_comparator,
   output reg  [HS_NUM-1:0] bootstrap_inhibit,
   output reg  [HS_NUM-1:0] hsGate,
   output reg  [HS_NUM-1:0] pumpSrcEn,
   output reg               pumpEnable,
   output reg               pumpClk,
   output reg               srcHighThreshold
);

   localparam integer SYN_W = 6 + 5 * HS_NUM;  // synchronised pin count

   // ---------------------------------------------------------------
   // pin synchronisers, two flops each
   // ---------------------------------------------------------------
   wire [SYN_W-1:0] pinRaw;   // raw asynchronous inputs
   reg  [SYN_W-1:0] syncA;    // first stage, read only by syncB
   reg  [SYN_W-1:0] syncB;    // second stage, safe to use

   assign pinRaw = {bootBelowPump, srcBelowHigh, srcBelowLow, bootstrap_clamp,
                    bootNearSupply, supply_uv_rise_threshold, boost_supply,
                    logic_supply_5v, poweron_reset_n, driverEnable, device_reset_n};

   // two-stage capture of every pin
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         syncA <= {SYN_W{1'b0}};
         syncB <= {SYN_W{1'b0}};
      end
      else
      begin
         syncA <= pinRaw;
         syncB <= syncA;
      end
   end

   wire              devRstN   = syncB[0];   // device reset, low active
   wire              drvEn     = syncB[1];   // driver enable
   wire              porN      = syncB[2];   // power-on reset, low active
   wire              vcc5Ok    = syncB[3];   // 5 V logic supply present
   wire              boostOk   = syncB[4];   // boost above 4.7 V
   wire              supplyUp  = syncB[5];   // predriver supply above rise level
   wire [HS_NUM-1:0] bootNear  = syncB[6 +: HS_NUM];
   wire [HS_NUM-1:0] clampOn   = syncB[6 + HS_NUM +: HS_NUM];
   wire [HS_NUM-1:0] srcLow    = syncB[6 + 2 * HS_NUM +: HS_NUM];
   wire [HS_NUM-1:0] srcHigh   = syncB[6 + 3 * HS_NUM +: HS_NUM];
   wire [HS_NUM-1:0] belowPump = syncB[6 + 4 * HS_NUM +: HS_NUM];

   // ---------------------------------------------------------------
   // apb register file
   // ---------------------------------------------------------------
   reg  [15:0] assoc12;      // channels 1 and 2 low-side pairing
   reg  [15:0] assoc34;      // channels 3 and 4 low-side pairing
   reg  [15:0] assoc5;       // channel 5 low-side pairing
   wire [9:0]  regIdx;       // word index of the access
   wire        hitAssoc12;   // decode hits
   wire        hitAssoc34;
   wire        hitAssoc5;
   wire        hitStatus;
   wire        mapped;       // any register hit
   wire        wrStrobe;     // write takes effect this edge
   wire [31:0] statusWord;   // live status

   assign regIdx     = paddr[11:2];
   assign hitAssoc12 = (regIdx == `BIS_ASSOC12_IDX);
   assign hitAssoc34 = (regIdx == `BIS_ASSOC34_IDX);
   assign hitAssoc5  = (regIdx == `BIS_ASSOC5_IDX);
   assign hitStatus  = (regIdx == `BIS_STATUS_IDX);
   assign mapped     = hitAssoc12 | hitAssoc34 | hitAssoc5 | hitStatus;
   // zero-wait slave; unmapped access answers with an error
   assign pready     = 1'b1;
   assign pslverr    = psel & penable & ~mapped;
   assign wrStrobe   = psel & penable & pwrite & mapped;

   // pairing registers written by software
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         assoc12 <= `BIS_ASSOC12_RST;
         assoc34 <= `BIS_ASSOC34_RST;
         assoc5  <= `BIS_ASSOC5_RST;
      end
      else if (wrStrobe)
      begin
         if (hitAssoc12)
            assoc12 <= pwdata[15:0] & `BIS_ASSOC_MASK;
         if (hitAssoc34)
            assoc34 <= pwdata[15:0] & `BIS_ASSOC_MASK;
         if (hitAssoc5)
            assoc5 <= {8'h00, pwdata[7:0] & 8'h3F};
      end
   end

   // read data captured in the setup cycle, valid in the access cycle
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         prdata <= 32'h00000000;
      else if (psel & ~penable & ~pwrite)
      begin
         if (hitAssoc12)
            prdata <= {16'h0000, assoc12};
         else if (hitAssoc34)
            prdata <= {16'h0000, assoc34};
         else if (hitAssoc5)
            prdata <= {16'h0000, assoc5};
         else if (hitStatus)
            prdata <= statusWord;
         else
            prdata <= 32'h00000000;
      end
   end

   // per-channel association vectors
   wire [LS_NUM-1:0] assocOf [0:HS_NUM-1];
   assign assocOf[0] = assoc12[`BIS_ODD_LSB  +: LS_NUM];
   assign assocOf[1] = assoc12[`BIS_EVEN_LSB +: LS_NUM];
   assign assocOf[2] = assoc34[`BIS_ODD_LSB  +: LS_NUM];
   assign assocOf[3] = assoc34[`BIS_EVEN_LSB +: LS_NUM];
   assign assocOf[4] = assoc5[`BIS_ODD_LSB   +: LS_NUM];

   // ---------------------------------------------------------------
   // supply qualification and threshold window
   // ---------------------------------------------------------------
   reg                    started;    // supply seen above rise level
   reg [`BIS_WIN_W-1:0]   winCount;   // cycles since rise
   reg                    winOpen;    // low threshold still applies

   // latch the first rise and time the window from it
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         started  <= 1'b0;
         winCount <= {`BIS_WIN_W{1'b0}};
         winOpen  <= 1'b1;
      end
      else if (!started)
      begin
         // gated by the released device reset
         if (supplyUp & devRstN)
            started <= 1'b1;
      end
      else if (winOpen)
      begin
         // low threshold during the window, high after
         if (winCount == WIN_CYC[`BIS_WIN_W-1:0] - 1'b1)
            winOpen <= 1'b0;
         winCount <= winCount + 1'b1;
      end
   end

   // source condition under the time-dependent threshold
   wire [HS_NUM-1:0] srcOk = winOpen ? srcLow : srcHigh;
   wire              anyLsOn = |lsOnReq;

   // ---------------------------------------------------------------
   // per-channel sequencers and outputs
   // ---------------------------------------------------------------
   wire [HS_NUM-1:0] chInit;   // channel initializing
   wire [HS_NUM-1:0] chDone;   // channel finished
   wire [HS_NUM-1:0] chExit;   // exit request

   genvar g;
   generate
      for (g = 0; g < HS_NUM; g = g + 1)
      begin : gCh
         // exit on any of the five conditions
         assign chExit[g] = (bootNear[g] & srcOk[g])
                          | (clampOn[g] & srcOk[g])
                          | (|(lsOnReq & assocOf[g]))
                          | ~(|assocOf[g])
                          | hsOnReq[g];

         // channel state machine
         bis_channel uCh
         (
            .clk          (mclk),
            .resetn       (resetn),
            .start        (started),
            .exitReq      (chExit[g]),
            .initializing (chInit[g]),
            .done         (chDone[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // charge pump enable, start-up time and clock
   // ---------------------------------------------------------------
   reg [`BIS_CPINIT_W-1:0] cpCount;   // start-up cycles elapsed
   reg                     pumpReady; // pump output usable
   reg [`BIS_CP_DIV_W-1:0] cpDiv;     // pump clock divider
   wire                    pumpRun;   // pump allowed to run

   // pump runs only with all three supply conditions
   assign pumpRun = vcc5Ok & boostOk & porN;

   // start-up timer restarts whenever the pump stops
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cpCount   <= {`BIS_CPINIT_W{1'b0}};
         pumpReady <= 1'b0;
      end
      else if (!pumpRun)
      begin
         cpCount   <= {`BIS_CPINIT_W{1'b0}};
         pumpReady <= 1'b0;
      end
      else if (!pumpReady)
      begin
         if (cpCount == `BIS_CPINIT_CYC - 1)
            pumpReady <= 1'b1;
         cpCount <= cpCount + 1'b1;
      end
   end

   // divide the system clock down to the pump rate
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cpDiv   <= {`BIS_CP_DIV_W{1'b0}};
         pumpClk <= 1'b0;
      end
      else if (!pumpRun)
      begin
         // clock stopped while the pump is held off
         cpDiv   <= {`BIS_CP_DIV_W{1'b0}};
         pumpClk <= 1'b0;
      end
      else
      begin
         if (cpDiv == `BIS_CP_DIV - 1)
            cpDiv <= {`BIS_CP_DIV_W{1'b0}};
         else
            cpDiv <= cpDiv + 1'b1;
         pumpClk <= (cpDiv < `BIS_CP_DIV / 2);
      end
   end

   // ---------------------------------------------------------------
   // registered drive outputs
   // ---------------------------------------------------------------
   // all outputs registered; reset forces safe levels
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         lsBiasEn          <= 1'b0;
         hsBiasEn          <= {HS_NUM{1'b0}};
         diodeLimit        <= {HS_NUM{1'b0}};
         source_comparator <= {HS_NUM{1'b0}};
         bootstrap_inhibit <= {HS_NUM{1'b0}};
         hsGate            <= {HS_NUM{1'b0}};
         pumpSrcEn         <= {HS_NUM{1'b0}};
         pumpEnable        <= 1'b0;
         srcHighThreshold  <= 1'b0;
      end
      else
      begin
         // low-side bias on while any channel charges
         lsBiasEn          <= |chInit;
         // high-side bias off during init and under boost lockout
         hsBiasEn          <= hsOnReq & ~chInit & {HS_NUM{boostOk}};
         // diode current limit and forced comparator in init
         diodeLimit        <= chInit;
         source_comparator <= chInit;
         // inhibit while no low side conducts
         bootstrap_inhibit <= (chInit | injectionEnd) & {HS_NUM{~anyLsOn}};
         // gate low on reset, disable or boost lockout
         hsGate            <= hsOnReq & ~chInit
                              & {HS_NUM{devRstN & drvEn & boostOk}};
         // current sources only while below pump output
         pumpSrcEn         <= belowPump & {HS_NUM{pumpReady}};
         pumpEnable        <= pumpRun;
         srcHighThreshold  <= started & ~winOpen;
      end
   end

   // status word seen by software
   assign statusWord = {19'h00000, pumpReady, pumpRun, winOpen,
                        chDone, chInit};

endmodule

`default_nettype wire

// file: sim/bis_sequencer_monitor.sv
// port checker for the bootstrap start-up sequencer
// assumes it is bound to bis_sequencer and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "bis_map.vh"

module bis_sequencer_monitor
#(
   parameter integer HS_NUM  = 5,
   parameter integer LS_NUM  = 6,
   parameter integer WIN_CYC = 200
)
(
   input wire logic              mclk,
   input wire logic              resetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [11:0]       paddr,
   input wire logic              pslverr,
   input wire logic              driverEnable,
   input wire logic              poweron_reset_n,
   input wire logic              logic_supply_5v,
   input wire logic              boost_supply,
   input wire logic [LS_NUM-1:0] lsOnReq,
   input wire logic [HS_NUM-1:0] hsOnReq,
   input wire logic [HS_NUM-1:0] injectionEnd,
   input wire logic              lsBiasEn,
   input wire logic [HS_NUM-1:0] hsBiasEn,
   input wire logic [HS_NUM-1:0] diodeLimit,
   input wire logic [HS_NUM-1:0] source_comparator,
   input wire logic [HS_NUM-1:0] bootstrap_inhibit,
   input wire logic [HS_NUM-1:0] hsGate,
   input wire logic              pumpEnable,
   input wire logic              pumpClk
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   logic [HS_NUM-1:0] prevInit;  // init flags one edge ago
   logic [HS_NUM-1:0] ended;     // channels whose init phase has ended

   // remember every channel that has left its init phase
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         prevInit <= '0;
         ended    <= '0;
      end
      else
      begin
         prevInit <= diodeLimit;
         ended    <= ended | (prevInit & ~diodeLimit);
      end
   end

   property p_apbErr;
      psel && penable |-> pslverr == (paddr[11:2] < `BIS_ASSOC12_IDX
                                      || paddr[11:2] > `BIS_STATUS_IDX);
   endproperty
   a_apbErr: assert property (p_apbErr) else $error("bad error response");
   property p_gateOff;
      (!driverEnable || !boost_supply)[*4] |-> hsGate == '0;
   endproperty
   a_gateOff: assert property (p_gateOff) else $error("gate not forced low");
   property p_pumpStop;
      (!poweron_reset_n || !logic_supply_5v || !boost_supply)[*4] |-> !pumpEnable;
   endproperty
   a_pumpStop: assert property (p_pumpStop) else $error("pump running");
   property p_initOut;
      diodeLimit != 0 |-> lsBiasEn && (hsBiasEn & diodeLimit) == 0
                          && source_comparator == diodeLimit;
   endproperty
   a_initOut: assert property (p_initOut) else $error("init outputs wrong");
   property p_once;
      (diodeLimit & ended) == 0;
   endproperty
   a_once: assert property (p_once) else $error("channel restarted init");
   property p_hsExit;
      (diodeLimit & hsOnReq) != 0 |-> ##[1:2] (diodeLimit & hsOnReq) == 0;
   endproperty
   a_hsExit: assert property (p_hsExit) else $error("init kept after high-side on");
   property p_inhibSet;
      (lsOnReq == 0 && injectionEnd != 0)[*2]
         |-> (bootstrap_inhibit & $past(injectionEnd)) == $past(injectionEnd);
   endproperty
   a_inhibSet: assert property (p_inhibSet) else $error("inhibit missing");
   property p_inhibClr;
      (lsOnReq != 0)[*2] |-> bootstrap_inhibit == 0;
   endproperty
   a_inhibClr: assert property (p_inhibClr) else $error("inhibit with low side on");
   property p_pumpClk;
      @(posedge mclk) disable iff (!resetn || !boost_supply || !pumpEnable)
      $rose(pumpClk) |=> pumpClk[*2] ##1 !pumpClk[*4] ##1 pumpClk;
   endproperty
   a_pumpClk: assert property (p_pumpClk) else $error("pump clock period wrong");
endmodule

bind bis_sequencer bis_sequencer_monitor
   #(.HS_NUM(HS_NUM), .LS_NUM(LS_NUM), .WIN_CYC(WIN_CYC)) mon (
   .mclk, .resetn, .psel, .penable, .paddr, .pslverr, .driverEnable, .poweron_reset_n,
   .logic_supply_5v, .boost_supply, .lsOnReq, .hsOnReq, .injectionEnd, .lsBiasEn, .hsBiasEn,
   .diodeLimit, .source_comparator, .bootstrap_inhibit, .hsGate, .pumpEnable, .pumpClk);

`default_nettype wire

// file: sim/bis_far_model.sv
// far-side model: bootstrap capacitors, source nodes and their comparators
// assumes low-side biasing charges every capacitor while it is on
`timescale 1ns/1ps
`default_nettype none

module bis_far_model
(
   input  wire logic       mclk,
   input  wire logic       lsBiasEn,
   input  wire logic [4:0] clampSel,
   input  wire logic [4:0] srcMid,
   output var  logic [4:0] bootNearSupply,
   output wire logic [4:0] bootstrap_clamp,
   output wire logic [4:0] srcBelowLow,
   output wire logic [4:0] srcBelowHigh,
   output var  logic [4:0] bootBelowPump
);
   int chg [5] = '{0, 0, 0, 0, 0};  // charge time per capacitor

   // capacitors charge while low sides are biased
   always @(posedge mclk)
   begin
      for (int i = 0; i < 5; i++)
         if (lsBiasEn && chg[i] < 1000)
            chg[i] <= chg[i] + 1;
   end

   logic [4:0] charged;  // node charged to its near or clamp level

   // node charged after a per-channel time; pump output sits higher still
   always_comb
   begin
      for (int i = 0; i < 5; i++)
      begin
         charged[i]       = chg[i] >= 60 + 10 * i;
         bootBelowPump[i] = chg[i] < 125 + 50 * i;
      end
   end

   // a clamped node is held just under the near level, so only its clamp reports
   assign bootNearSupply  = charged & ~clampSel;
   assign bootstrap_clamp = charged & clampSel;
   assign srcBelowLow     = ~srcMid;                    // mid sources sit above 0.5 V
   assign srcBelowHigh    = 5'h1F;
endmodule

`default_nettype wire

// file: sim/bis_sequencer_tb_top.sv
// self-checking bench for the bootstrap start-up sequencer
// assumes the design, its checker and the far-side model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "bis_map.vh"
`define CHK(a, e) check((a) === (e));

module bis_sequencer_tb_top;
   logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, w, seed = 32'h0000002A;
   logic devRstN = 1, driverEnable = 1, porN = 0, v5 = 1, boost = 1, supplyUp = 0;
   logic [4:0] near, clamp, srcLow, srcHigh, belowPump, hsOn = 0, inj = 0;
   logic [4:0] hsBias, diodeLim, srcCmp, inhib, hsGate, pumpSrc;
   logic [5:0] lsOn = 0;
   logic lsBias, pumpEn, pumpClk, srcHiThr;
   int failures = 0, checksDone = 0;

   always #2.5 mclk = ~mclk;

   bis_sequencer #(.WIN_CYC(200)) uut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .pslverr, .prdata, .device_reset_n(devRstN), .driverEnable,
      .poweron_reset_n(porN), .logic_supply_5v(v5), .boost_supply(boost),
      .supply_uv_rise_threshold(supplyUp), .bootNearSupply(near), .bootstrap_clamp(clamp),
      .srcBelowLow(srcLow), .srcBelowHigh(srcHigh), .bootBelowPump(belowPump),
      .lsOnReq(lsOn), .hsOnReq(hsOn), .injectionEnd(inj), .lsBiasEn(lsBias),
      .hsBiasEn(hsBias), .diodeLimit(diodeLim), .source_comparator(srcCmp),
      .bootstrap_inhibit(inhib), .hsGate, .pumpSrcEn(pumpSrc), .pumpEnable(pumpEn),
      .pumpClk, .srcHighThreshold(srcHiThr));

   bis_far_model fm (.mclk, .lsBiasEn(lsBias), .clampSel(5'h02), .srcMid(5'h02),
      .bootNearSupply(near), .bootstrap_clamp(clamp), .srcBelowLow(srcLow),
      .srcBelowHigh(srcHigh), .bootBelowPump(belowPump));

   // xorshift source for register data
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // stored value of an association register
   function automatic logic [31:0] expAssoc(input logic [9:0] idx, input logic [31:0] d);
      return {16'h0000, d[15:0] & (idx == `BIS_ASSOC5_IDX ? 16'h003F : `BIS_ASSOC_MASK)};
   endfunction

   task automatic check(input logic ok);
      checksDone++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("MISMATCH t=%0t value differs", $time);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one apb transfer; read data and error land in rd and err
   task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic testDone();
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // main sequence
   initial
   begin
      cyc(8);
      resetn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         apb(`BIS_ASSOC12_IDX + i, 1'b0, 32'h0);
         `CHK(rd, expAssoc(`BIS_ASSOC12_IDX + i, 32'hFFFF))
      end
      apb(10'h1AA, 1'b0, 32'h0);
      `CHK({err, rd}, 33'h100000000)
      for (int i = 0; i < 6; i++)
      begin
         w = xs();
         apb(`BIS_ASSOC12_IDX + i % 3, 1'b1, w);
         apb(`BIS_ASSOC12_IDX + i % 3, 1'b0, 32'h0);
         `CHK(rd, expAssoc(`BIS_ASSOC12_IDX + i % 3, w))
      end
      // pairs 1-ls1 2-ls2 3-ls3 4-ls4; channel 5 unused and cleared
      apb(`BIS_ASSOC12_IDX, 1'b1, 32'h0201);
      apb(`BIS_ASSOC34_IDX, 1'b1, 32'h0804);
      apb(`BIS_ASSOC5_IDX, 1'b1, 32'h0);
      `CHK({lsBias, diodeLim}, 6'h00)
      // supply rises above its rise level: default start-up sequence
      supplyUp <= 1'b1;
      cyc(8);
      `CHK({lsBias, diodeLim}, 6'h2F)
      apb(`BIS_STATUS_IDX, 1'b0, 32'h0);
      `CHK(rd[10:0], 11'h60F)
      // unshared low sides, so no blanking is needed here
      hsOn <= 5'h04;
      cyc(4);
      hsOn <= 5'h00;
      cyc(2);
      `CHK(diodeLim, 5'h0B)
      lsOn <= 6'h08;
      cyc(4);
      lsOn <= 6'h00;
      cyc(2);
      `CHK(diodeLim, 5'h03)
      cyc(70);
      `CHK({srcHiThr, diodeLim}, 6'h02)
      cyc(130);
      `CHK({srcHiThr, diodeLim}, 6'h20)
      apb(`BIS_STATUS_IDX, 1'b0, 32'h0);
      `CHK(rd[10:0], 11'h3E0)
      inj <= 5'h1F;
      cyc(3);
      `CHK(inhib, 5'h1F)
      lsOn <= 6'h01;
      cyc(3);
      `CHK(inhib, 5'h00)
      lsOn <= 6'h00;
      inj  <= 5'h00;
      `CHK(pumpEn, 1'b0)
      porN <= 1'b1;
      cyc(6);
      `CHK(pumpEn, 1'b1)
      cyc(1950);
      apb(`BIS_STATUS_IDX, 1'b0, 32'h0);
      `CHK(rd[12:11], 2'b01)
      `CHK(pumpSrc, 5'h00)
      cyc(60);
      apb(`BIS_STATUS_IDX, 1'b0, 32'h0);
      `CHK(rd[12:11], 2'b11)
      `CHK(pumpSrc, 5'h1C)
      hsOn <= 5'h1F;
      cyc(6);
      `CHK({hsGate, hsBias}, 10'h3FF)
      driverEnable <= 1'b0;
      cyc(6);
      `CHK({hsGate, hsBias}, 10'h01F)
      driverEnable <= 1'b1;
      boost <= 1'b0;
      cyc(6);
      `CHK({hsGate, hsBias}, 10'h000)
      // boost back, device reset pin asserted: gates stay low, bias returns
      boost   <= 1'b1;
      devRstN <= 1'b0;
      cyc(6);
      `CHK({hsGate, hsBias}, 10'h01F)
      testDone();
   end

   // hang guard
   initial
   begin
      #40000;
      failures++;
      testDone();
   end
endmodule

`default_nettype wire
